/* File: core/sgflc_pkg.sv */
// Contract
// - Station address, low byte here, is pause source and self-filter key.
// - A 14-bit payload limit resets to 2000; longer frames are truncated.
// - The limit takes values up to 9000 for jumbo use, set by software.
// - A 16-bit tag type resets to 0x9100 for untagged frames and outer tag.
// - Double tagging applies only while its enable, clear at reset, is set.
// - Shaper charges data plus gap and preamble at 1, data only at 0 (default).
// - Policer charges data plus gap and preamble at 1 (default), data only at 0.
// - A master VLAN enable, clear at reset, turns VLAN forwarding on.
// - Invalid-VLAN frames drop when the bit is 1 (default), else go to host.
// - Enabled unknown-VLAN forwarding overrides the drop choice for unknown IDs.
// - Each dynamic entry update writes the 3-bit age count, reset binary 100.
// - Aging time comes from age count and the separate age period.
// - A reserved-multicast lookup enable, clear at reset, gates that table.
// - 2-bit hash select: 00 and 11 direct low 10 bits, 01 CRC, 10 XOR.
`default_nettype none
package sgflc_pkg;
    // ****
    // Register indices, byte address = 4 * index
    // ****
    localparam logic [9:0] IDX_SWITCH_OP = 10'h300;
    localparam logic [9:0] IDX_STATION_BYTE5 = 10'h307;
    localparam logic [9:0] IDX_MAX_PAYLOAD = 10'h308;
    localparam logic [9:0] IDX_PROVIDER_TAG = 10'h30a;
    localparam logic [9:0] IDX_SHAPER_ACCT = 10'h30e;
    localparam logic [9:0] IDX_LOOKUP_CTL0 = 10'h310;
    localparam logic [9:0] IDX_VLAN_AUX = 10'h320;
    localparam logic [9:0] IDX_AGE_PERIOD = 10'h321;

    // ****
    // Reset values
    // ****
    localparam logic [7:0] RST_STATION_BYTE5 = 8'hff;
    localparam logic [15:0] RST_MAX_PAYLOAD = 16'h07d0;
    localparam logic [15:0] RST_PROVIDER_TAG = 16'h9100;
    localparam logic [1:0] RST_SHAPER_ACCT = 2'h1;
    localparam logic [7:0] RST_LOOKUP_CTL0 = 8'h61;
    localparam logic [7:0] RST_SWITCH_OP = 8'h00;
    localparam logic [7:0] RST_VLAN_AUX = 8'h00;
    localparam logic [7:0] RST_AGE_PERIOD = 8'h01;

    // ****
    // Field positions
    // ****
    localparam int unsigned BIT_DOUBLE_TAG = 7;
    localparam int unsigned BIT_SHAPE_ACCT = 1;
    localparam int unsigned BIT_POLICE_ACCT = 0;
    localparam int unsigned BIT_VLAN_EN = 7;
    localparam int unsigned BIT_DROP_INVALID = 6;
    localparam int unsigned AGE_CNT_HI = 5;
    localparam int unsigned AGE_CNT_LO = 3;
    localparam int unsigned BIT_RSVD_MCAST = 2;
    localparam int unsigned HASH_HI = 1;
    localparam int unsigned HASH_LO = 0;
    localparam int unsigned BIT_UNKNOWN_FWD = 0;
    localparam int unsigned LIMIT_W = 14;

    // ****
    // Widths, hashing, framing overhead
    // ****
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned HASH_W = 10;
    localparam int unsigned MAC_W = 48;
    localparam logic [9:0] CRC_POLY = 10'h233;
    localparam logic [14:0] IPG_BYTES = 15'h00c;
    localparam logic [14:0] PREAMBLE_BYTES = 15'h008;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_DECODE_ERR = 2'h3;

    typedef enum logic [1:0] {
        SGFLC_HASH_DIRECT0,
        SGFLC_HASH_CRC,
        SGFLC_HASH_XOR,
        SGFLC_HASH_DIRECT3
    } sgflc_hash_e;
endpackage
`default_nettype wire

/* File: core/sgflc_cfg_hold.sv */
`default_nettype none
// ****
// Frame-boundary copy of one setting
// ****
module sgflc_cfg_hold
    import sgflc_pkg::*;
#(
    parameter int unsigned W = 8,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Load strobe and value
    input wire logic load,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] hold_q;
    logic [W-1:0] hold_d;

    // Width sanity
    if (W < 1) begin : g_bad_w
        $error("sgflc_cfg_hold: W must be at least 1");
    end

    // Reload only at frame start, so a frame sees one setting
    always_comb begin
        hold_d = hold_q;
        if (load) begin
            hold_d = din;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hold_q <= RST;
        end else begin
            hold_q <= hold_d;
        end
    end

    assign dout = hold_q;
endmodule
`default_nettype wire

/* File: core/sgflc_top.sv */
// Decided for this implementation: the Avalon-MM slave port.
`default_nettype none
// ****
// Global switch and lookup configuration
// ****
module sgflc_top
    import sgflc_pkg::*;
#(
    parameter int unsigned HIGH_ADDR_W = 40
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    // Station high bytes
    input wire logic [HIGH_ADDR_W-1:0] station_addr_hi,
    // Frame descriptor
    input wire logic frame_start,
    input wire logic [LIMIT_W-1:0] frame_payload_len,
    input wire logic [LIMIT_W-1:0] frame_bytes,
    input wire logic [MAC_W-1:0] frame_dst_addr,
    input wire logic [MAC_W-1:0] frame_src_addr,
    input wire logic frame_vid_invalid,
    input wire logic frame_vid_unknown,
    // Active settings
    output logic [MAC_W-1:0] station_addr,
    output logic [15:0] provider_outer_tag,
    output logic double_tag_en,
    output logic vlan_enable,
    output logic rsvd_mcast_lookup_en,
    output logic [1:0] table_hash_select,
    output logic [2:0] entry_age_count,
    output logic [10:0] aging_time,
    // Per-frame results
    output logic res_valid,
    output logic res_truncate,
    output logic [LIMIT_W-1:0] res_payload_len,
    output logic [14:0] res_shaper_charge,
    output logic [14:0] res_policer_charge,
    output logic res_drop,
    output logic res_to_host,
    output logic res_unknown_fwd,
    output logic res_self_match,
    output logic [HASH_W-1:0] res_hash_index
);
    // Elaboration check
    if (HIGH_ADDR_W != MAC_W - 8) begin : g_bad_hi
        $error("sgflc_top: HIGH_ADDR_W must be 40");
    end

    // ****
    // Helpers
    // ****
    // Byte-lane merge
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        logic [15:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        if (be[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    // Serial CRC of the DA
    function automatic logic [HASH_W-1:0] crc_hash(input logic [MAC_W-1:0] a);
        logic [HASH_W-1:0] c;
        logic fb;
        c = '1;
        for (int i = MAC_W - 1; i >= 0; i--) begin
            fb = c[HASH_W-1] ^ a[i];
            c = {c[HASH_W-2:0], 1'b0};
            if (fb) begin
                c = c ^ CRC_POLY;
            end
        end
        return c;
    endfunction

    // XOR fold to ten bits
    function automatic logic [HASH_W-1:0] xor_hash(input logic [MAC_W-1:0] a);
        logic [HASH_W*5-1:0] p;
        logic [HASH_W-1:0] x;
        p = {2'b00, a};
        x = '0;
        for (int i = 0; i < 5; i++) begin
            x = x ^ p[i*HASH_W +: HASH_W];
        end
        return x;
    endfunction

    // ****
    // Bus and register state
    // ****
    logic wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] resp_q, resp_d;
    logic [7:0] mac5_q, mac5_d;
    logic [15:0] mtu_q, mtu_d;
    logic [15:0] tag_q, tag_d;
    logic [1:0] acct_q, acct_d;
    logic [7:0] luc0_q, luc0_d;
    logic dtag_q, dtag_d;
    logic unk_q, unk_d;
    logic [7:0] agep_q, agep_d;
    logic [9:0] idx;
    logic req;
    logic hit;

    assign idx = avs_address[ADDR_W-1:2];
    assign req = avs_read | avs_write;
    assign hit = (avs_address[1:0] == 2'b00) &&
                 (idx == IDX_SWITCH_OP || idx == IDX_STATION_BYTE5 ||
                  idx == IDX_MAX_PAYLOAD || idx == IDX_PROVIDER_TAG ||
                  idx == IDX_SHAPER_ACCT || idx == IDX_LOOKUP_CTL0 ||
                  idx == IDX_VLAN_AUX || idx == IDX_AGE_PERIOD);

    // One wait state, then the answer
    always_comb begin
        wait_d = 1'b1;
        rdata_d = rdata_q;
        resp_d = resp_q;
        mac5_d = mac5_q;
        mtu_d = mtu_q;
        tag_d = tag_q;
        acct_d = acct_q;
        luc0_d = luc0_q;
        dtag_d = dtag_q;
        unk_d = unk_q;
        agep_d = agep_q;
        if (req && wait_q) begin
            wait_d = 1'b0;
            resp_d = hit ? RESP_OK : RESP_DECODE_ERR;
            rdata_d = '0;
            if (avs_read && hit) begin
                case (idx)
                    IDX_SWITCH_OP: rdata_d[BIT_DOUBLE_TAG] = dtag_q;
                    IDX_STATION_BYTE5: rdata_d[7:0] = mac5_q;
                    IDX_MAX_PAYLOAD: rdata_d[15:0] = mtu_q;
                    IDX_PROVIDER_TAG: rdata_d[15:0] = tag_q;
                    IDX_SHAPER_ACCT: rdata_d[1:0] = acct_q;
                    IDX_LOOKUP_CTL0: rdata_d[7:0] = luc0_q;
                    IDX_VLAN_AUX: rdata_d[BIT_UNKNOWN_FWD] = unk_q;
                    IDX_AGE_PERIOD: rdata_d[7:0] = agep_q;
                    default: rdata_d = '0;
                endcase
            end
        end
        // Write lands as the handshake ends
        if (avs_write && !wait_q && hit) begin
            case (idx)
                IDX_SWITCH_OP: begin
                    if (avs_byteenable[0]) begin
                        dtag_d = avs_writedata[BIT_DOUBLE_TAG];
                    end
                end
                IDX_STATION_BYTE5: begin
                    if (avs_byteenable[0]) begin
                        mac5_d = avs_writedata[7:0];
                    end
                end
                IDX_MAX_PAYLOAD: mtu_d = merge16(mtu_q, avs_writedata, avs_byteenable);
                IDX_PROVIDER_TAG: tag_d = merge16(tag_q, avs_writedata, avs_byteenable);
                IDX_SHAPER_ACCT: begin
                    if (avs_byteenable[0]) begin
                        acct_d = avs_writedata[1:0];
                    end
                end
                IDX_LOOKUP_CTL0: begin
                    if (avs_byteenable[0]) begin
                        luc0_d = avs_writedata[7:0];
                    end
                end
                IDX_VLAN_AUX: begin
                    if (avs_byteenable[0]) begin
                        unk_d = avs_writedata[BIT_UNKNOWN_FWD];
                    end
                end
                IDX_AGE_PERIOD: begin
                    if (avs_byteenable[0]) begin
                        agep_d = avs_writedata[7:0];
                    end
                end
                default: unk_d = unk_q;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wait_q <= 1'b1;
            rdata_q <= '0;
            resp_q <= RESP_OK;
            mac5_q <= RST_STATION_BYTE5;
            mtu_q <= RST_MAX_PAYLOAD;
            tag_q <= RST_PROVIDER_TAG;
            acct_q <= RST_SHAPER_ACCT;
            luc0_q <= RST_LOOKUP_CTL0;
            dtag_q <= RST_SWITCH_OP[BIT_DOUBLE_TAG];
            unk_q <= RST_VLAN_AUX[BIT_UNKNOWN_FWD];
            agep_q <= RST_AGE_PERIOD;
        end else begin
            wait_q <= wait_d;
            rdata_q <= rdata_d;
            resp_q <= resp_d;
            mac5_q <= mac5_d;
            mtu_q <= mtu_d;
            tag_q <= tag_d;
            acct_q <= acct_d;
            luc0_q <= luc0_d;
            dtag_q <= dtag_d;
            unk_q <= unk_d;
            agep_q <= agep_d;
        end
    end

    assign avs_waitrequest = wait_q;
    assign avs_readdata = rdata_q;
    assign avs_response = resp_q;

    // ****
    // Active settings, swapped at frame start
    // ****
    logic [7:0] luc_active;
    // frame in flight keeps old copy
    sgflc_cfg_hold #(.W(MAC_W), .RST({40'h0, RST_STATION_BYTE5})) u_hold_mac (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .load(frame_start),
        .din({station_addr_hi, mac5_q}),
        .dout(station_addr)
    );
    sgflc_cfg_hold #(.W(16), .RST(RST_PROVIDER_TAG)) u_hold_tag (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .load(frame_start),
        .din(tag_q),
        .dout(provider_outer_tag)
    );
    sgflc_cfg_hold #(.W(8), .RST(RST_LOOKUP_CTL0)) u_hold_luc (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .load(frame_start),
        .din(luc0_q),
        .dout(luc_active)
    );
    sgflc_cfg_hold #(.W(1), .RST(RST_SWITCH_OP[BIT_DOUBLE_TAG])) u_hold_dtag (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .load(frame_start),
        .din(dtag_q),
        .dout(double_tag_en)
    );

    assign vlan_enable = luc_active[BIT_VLAN_EN];
    assign rsvd_mcast_lookup_en = luc_active[BIT_RSVD_MCAST];
    assign table_hash_select = luc_active[HASH_HI:HASH_LO];
    assign entry_age_count = luc_active[AGE_CNT_HI:AGE_CNT_LO];

    // ****
    // Per-frame evaluation
    // ****
    logic rv_q, rv_d;
    logic trunc_q, trunc_d;
    logic [LIMIT_W-1:0] plen_q, plen_d;
    logic [14:0] shp_q, shp_d;
    logic [14:0] pol_q, pol_d;
    logic drop_q, drop_d;
    logic host_q, host_d;
    logic ufwd_q, ufwd_d;
    logic self_q, self_d;
    logic [HASH_W-1:0] hidx_q, hidx_d;
    logic [10:0] age_q, age_d;
    logic [14:0] base;
    logic [LIMIT_W-1:0] limit;
    logic unk_take;

    assign base = {1'b0, frame_bytes};
    assign limit = mtu_q[LIMIT_W-1:0];
    assign unk_take = unk_q && frame_vid_unknown;

    // Settings as of frame start; aging time follows the live registers every cycle
    always_comb begin
        rv_d = frame_start;
        trunc_d = trunc_q;
        plen_d = plen_q;
        shp_d = shp_q;
        pol_d = pol_q;
        drop_d = drop_q;
        host_d = host_q;
        ufwd_d = ufwd_q;
        self_d = self_q;
        hidx_d = hidx_q;
        // aging time from count and period
        age_d = 11'(luc0_q[AGE_CNT_HI:AGE_CNT_LO]) * 11'(agep_q);
        if (frame_start) begin
            trunc_d = frame_payload_len > limit;
            plen_d = trunc_d ? limit : frame_payload_len;
            shp_d = acct_q[BIT_SHAPE_ACCT] ? base + IPG_BYTES + PREAMBLE_BYTES : base;
            pol_d = acct_q[BIT_POLICE_ACCT] ? base + IPG_BYTES + PREAMBLE_BYTES : base;
            ufwd_d = luc0_q[BIT_VLAN_EN] && unk_take;
            drop_d = luc0_q[BIT_VLAN_EN] && frame_vid_invalid && !unk_take &&
                     luc0_q[BIT_DROP_INVALID];
            host_d = luc0_q[BIT_VLAN_EN] && frame_vid_invalid && !unk_take &&
                     !luc0_q[BIT_DROP_INVALID];
            self_d = frame_src_addr == {station_addr_hi, mac5_q};
            case (sgflc_hash_e'(luc0_q[HASH_HI:HASH_LO]))
                SGFLC_HASH_CRC: hidx_d = crc_hash(frame_dst_addr);
                SGFLC_HASH_XOR: hidx_d = xor_hash(frame_dst_addr);
                default: hidx_d = frame_dst_addr[HASH_W-1:0];
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rv_q <= 1'b0;
            trunc_q <= 1'b0;
            plen_q <= '0;
            shp_q <= '0;
            pol_q <= '0;
            drop_q <= 1'b0;
            host_q <= 1'b0;
            ufwd_q <= 1'b0;
            self_q <= 1'b0;
            hidx_q <= '0;
            age_q <= '0;
        end else begin
            rv_q <= rv_d;
            trunc_q <= trunc_d;
            plen_q <= plen_d;
            shp_q <= shp_d;
            pol_q <= pol_d;
            drop_q <= drop_d;
            host_q <= host_d;
            ufwd_q <= ufwd_d;
            self_q <= self_d;
            hidx_q <= hidx_d;
            age_q <= age_d;
        end
    end

    assign res_valid = rv_q;
    assign res_truncate = trunc_q;
    assign res_payload_len = plen_q;
    assign res_shaper_charge = shp_q;
    assign res_policer_charge = pol_q;
    assign res_drop = drop_q;
    assign res_to_host = host_q;
    assign res_unknown_fwd = ufwd_q;
    assign res_self_match = self_q;
    assign res_hash_index = hidx_q;
    assign aging_time = age_q;
endmodule
`default_nettype wire

/* File: bench/sgflc_checker.sv */
`default_nettype none
// ****
// Port-level checks of the config block
// ****
module sgflc_checker
    import sgflc_pkg::*;
#(
    parameter int unsigned HIGH_ADDR_W = 40
) (
    // Clock, reset, bus handshake
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // Frame side
    input wire logic frame_start,
    input wire logic [LIMIT_W-1:0] frame_payload_len,
    input wire logic [LIMIT_W-1:0] frame_bytes,
    input wire logic [MAC_W-1:0] frame_dst_addr,
    input wire logic [MAC_W-1:0] frame_src_addr,
    input wire logic [MAC_W-1:0] station_addr,
    input wire logic [15:0] provider_outer_tag,
    input wire logic vlan_enable,
    input wire logic [1:0] table_hash_select,
    input wire logic res_valid,
    input wire logic res_truncate,
    input wire logic [LIMIT_W-1:0] res_payload_len,
    input wire logic [14:0] res_shaper_charge,
    input wire logic [14:0] res_policer_charge,
    input wire logic res_drop,
    input wire logic res_to_host,
    input wire logic res_self_match,
    input wire logic [HASH_W-1:0] res_hash_index
);
    logic [HASH_W-1:0] dst_low;
    // Plain slice for $past
    assign dst_low = frame_dst_addr[HASH_W-1:0];
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence s_req_pending;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_frame_answer;
        frame_start ##1 res_valid;
    endsequence
    a_bus_answer: assert property (s_req_pending |=> !avs_waitrequest)
        else $error("late answer");
    a_bus_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("long answer");
    a_frame_result: assert property (frame_start |-> s_frame_answer)
        else $error("no result");
    a_no_spurious: assert property (!frame_start |=> !res_valid)
        else $error("stray result");
    a_trunc_len: assert property (res_valid && !res_truncate |->
        res_payload_len == $past(frame_payload_len))
        else $error("length changed");
    a_trunc_short: assert property (res_valid && res_truncate |->
        res_payload_len < $past(frame_payload_len))
        else $error("cut not shorter");
    a_shaper_gap: assert property (res_valid |->
        (res_shaper_charge - {1'b0, $past(frame_bytes)}) inside {15'h000, 15'h014})
        else $error("shaper charge wrong");
    a_police_gap: assert property (res_valid |->
        (res_policer_charge - {1'b0, $past(frame_bytes)}) inside {15'h000, 15'h014})
        else $error("policer charge wrong");
    a_vlan_off: assert property (res_valid && !vlan_enable |-> !res_drop && !res_to_host)
        else $error("vlan action");
    a_hash_direct: assert property (res_valid && table_hash_select inside {2'h0, 2'h3} |->
        res_hash_index == $past(dst_low))
        else $error("direct hash");
    a_self_match: assert property (res_valid |->
        res_self_match == ($past(frame_src_addr) == station_addr))
        else $error("self match wrong");
    a_active_hold: assert property (!frame_start |=>
        $stable(provider_outer_tag) && $stable(vlan_enable))
        else $error("setting moved");
endmodule
bind sgflc_top sgflc_checker #(.HIGH_ADDR_W(HIGH_ADDR_W)) u_checker (
    .core_clk(core_clk), .sys_rst(sys_rst), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .frame_start(frame_start),
    .frame_payload_len(frame_payload_len), .frame_bytes(frame_bytes),
    .frame_dst_addr(frame_dst_addr), .frame_src_addr(frame_src_addr),
    .station_addr(station_addr), .provider_outer_tag(provider_outer_tag),
    .vlan_enable(vlan_enable), .table_hash_select(table_hash_select),
    .res_valid(res_valid), .res_truncate(res_truncate), .res_payload_len(res_payload_len),
    .res_shaper_charge(res_shaper_charge), .res_policer_charge(res_policer_charge),
    .res_drop(res_drop), .res_to_host(res_to_host), .res_self_match(res_self_match),
    .res_hash_index(res_hash_index)
);
`default_nettype wire

/* File: bench/tb_switch_global_frame_lookup_config.sv */
`default_nettype none
module tb_switch_global_frame_lookup_config
    import sgflc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, sys_rst, avs_read, avs_write, avs_waitrequest, frame_start, inv_q, unk_q;
    logic [11:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [1:0] avs_response, table_hash_select;
    logic [39:0] station_addr_hi;
    logic [13:0] frame_payload_len, frame_bytes, res_payload_len;
    logic [47:0] frame_dst_addr, frame_src_addr, station_addr;
    logic [15:0] provider_outer_tag;
    logic double_tag_en, vlan_enable, rsvd_mcast_lookup_en, res_valid, res_truncate;
    logic [2:0] entry_age_count;
    logic [10:0] aging_time;
    logic [14:0] res_shaper_charge, res_policer_charge;
    logic res_drop, res_to_host, res_unknown_fwd, res_self_match;
    logic [9:0] res_hash_index;
    int failures = 0;
    int tests_run = 0;
    sgflc_top u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .avs_response(avs_response), .station_addr_hi(station_addr_hi),
        .frame_start(frame_start), .frame_payload_len(frame_payload_len),
        .frame_bytes(frame_bytes), .frame_dst_addr(frame_dst_addr),
        .frame_src_addr(frame_src_addr), .frame_vid_invalid(inv_q),
        .frame_vid_unknown(unk_q), .station_addr(station_addr),
        .provider_outer_tag(provider_outer_tag), .double_tag_en(double_tag_en),
        .vlan_enable(vlan_enable), .rsvd_mcast_lookup_en(rsvd_mcast_lookup_en),
        .table_hash_select(table_hash_select), .entry_age_count(entry_age_count),
        .aging_time(aging_time), .res_valid(res_valid), .res_truncate(res_truncate),
        .res_payload_len(res_payload_len), .res_shaper_charge(res_shaper_charge),
        .res_policer_charge(res_policer_charge), .res_drop(res_drop),
        .res_to_host(res_to_host), .res_unknown_fwd(res_unknown_fwd),
        .res_self_match(res_self_match), .res_hash_index(res_hash_index));
    // Free-running core clock, 4 ns
    always #2 core_clk = ~core_clk;
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Held until waitrequest low
    task automatic bus(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic [1:0] rsp);
        int n;
        @(posedge core_clk);
        avs_address <= {idx, 2'b00};
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        for (n = 0; n < 20; n++) begin
            @(posedge core_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        rd = avs_readdata;
        rsp = avs_response;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n == 20) begin
            failures++;
            final_report();
        end
    endtask
    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic [1:0] s;
        bus(1'b1, idx, d, r, s);
    endtask
    task automatic rd_chk(input string what, input logic [9:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        logic [1:0] s;
        bus(1'b0, idx, 32'h0, r, s);
        check(what, r, exp);
        check("response", s, 2'h0);
    endtask
    // Result one edge after start
    task automatic frame(input logic [13:0] len, input logic [47:0] src, input logic inv,
                         input logic unk);
        @(posedge core_clk);
        frame_start <= 1'b1;
        frame_payload_len <= len;
        frame_src_addr <= src;
        inv_q <= inv;
        unk_q <= unk;
        @(posedge core_clk);
        frame_start <= 1'b0;
        @(posedge core_clk);
        check("res_valid", res_valid, 1'b1);
    endtask
    task automatic t_reset();
        logic [31:0] r;
        logic [1:0] s;
        rd_chk("station byte5", 10'h307, 32'hff);
        rd_chk("payload limit", 10'h308, 32'h07d0);
        rd_chk("tag type", 10'h30a, 32'h9100);
        rd_chk("accounting", 10'h30e, 32'h1);
        rd_chk("lookup ctl0", 10'h310, 32'h61);
        rd_chk("switch op", 10'h300, 32'h0);
        bus(1'b0, 10'h3ff, 32'h0, r, s);
        check("unmapped data", r, 32'h0);
        check("unmapped resp", s, 2'h3);
        $display("test reset done");
    endtask
    task automatic t_regs();
        wr(10'h30e, 32'hffff);
        rd_chk("accounting reserved", 10'h30e, 32'h3);
        wr(10'h308, 32'h2328);
        rd_chk("jumbo limit", 10'h308, 32'h2328);
        $display("test regs done");
    endtask
    task automatic t_trunc();
        frame(14'd9000, 48'h0, 1'b0, 1'b0);
        check("trunc at limit", {res_truncate, res_payload_len}, {1'b0, 14'd9000});
        frame(14'd9001, 48'h0, 1'b0, 1'b0);
        check("trunc over", {res_truncate, res_payload_len}, {1'b1, 14'd9000});
        wr(10'h308, 32'h07d0);
        frame(14'd2001, 48'h0, 1'b0, 1'b0);
        check("trunc default", {res_truncate, res_payload_len}, {1'b1, 14'd2000});
        $display("test trunc done");
    endtask
    task automatic t_charge();
        for (int a = 0; a < 4; a++) begin
            wr(10'h30e, a);
            frame(14'd100, 48'h0, 1'b0, 1'b0);
            check("shaper", res_shaper_charge, a[1] ? 15'd120 : 15'd100);
            check("policer", res_policer_charge, a[0] ? 15'd120 : 15'd100);
        end
        $display("test charge done");
    endtask
    task automatic t_lookup();
        for (int h = 0; h < 4; h++) begin
            wr(10'h310, 32'hd4 | h);
            frame(14'd64, 48'h0, 1'b0, 1'b0);
            check("hash select", table_hash_select, h[1:0]);
            check("age count", {vlan_enable, rsvd_mcast_lookup_en, entry_age_count}, 5'h1a);
            check("aging time", aging_time, 11'd2);
            if (h == 0 || h == 3) check("direct hash", res_hash_index, 10'h2bc);
        end
        wr(10'h310, 32'hd1);
        frame(14'd64, 48'h0, 1'b1, 1'b0);
        check("invalid drop", {res_drop, res_to_host}, 2'b10);
        wr(10'h310, 32'h91);
        frame(14'd64, 48'h0, 1'b1, 1'b0);
        check("invalid to host", {res_drop, res_to_host}, 2'b01);
        wr(10'h320, 32'h1);
        wr(10'h310, 32'hd1);
        frame(14'd64, 48'h0, 1'b1, 1'b1);
        check("unknown fwd", {res_unknown_fwd, res_drop}, 2'b10);
        wr(10'h310, 32'h51);
        frame(14'd64, 48'h0, 1'b1, 1'b0);
        check("vlan off", {res_drop, res_to_host}, 2'b00);
        $display("test lookup done");
    endtask
    task automatic t_active();
        wr(10'h307, 32'ha5);
        wr(10'h30a, 32'h88a8);
        wr(10'h300, 32'h80);
        check("tag before frame", {double_tag_en, provider_outer_tag}, 17'h09100);
        frame(14'd64, 48'h0102_0304_05a5, 1'b0, 1'b0);
        check("station addr", station_addr, 48'h0102_0304_05a5);
        check("self match", res_self_match, 1'b1);
        check("tag after frame", {double_tag_en, provider_outer_tag}, 17'h188a8);
        $display("test active done");
    endtask
    // Reset, then scenarios
    initial begin
        core_clk = 1'b0;
        sys_rst = 1'b1;
        {avs_read, avs_write, frame_start, inv_q, unk_q} = 5'h0;
        avs_address = 12'h0;
        avs_writedata = 32'h0;
        station_addr_hi = 40'h01_0203_0405;
        frame_payload_len = 14'h0;
        frame_bytes = 14'd100;
        frame_dst_addr = 48'h1234_5678_9abc;
        frame_src_addr = 48'h0;
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_regs();
        t_trunc();
        t_charge();
        t_lookup();
        t_active();
        final_report();
    end
endmodule
`default_nettype wire
